// ==== inc/usbdev_pkg.sv ====
// Package with register map, field layout and timing for the endpoint logic.
package usbdev_pkg;
    localparam logic [7:0] ADDR_DEV = 8'h10;
    localparam logic [7:0] ADDR_EP0_CNT = 8'h11;
    localparam logic [7:0] ADDR_EP0_MODE = 8'h12;
    localparam logic [7:0] ADDR_EP1_CNT = 8'h13;
    localparam logic [7:0] ADDR_EP1_MODE = 8'h14;
    localparam logic [7:0] ADDR_EP2_CNT = 8'h15;
    localparam logic [7:0] ADDR_EP2_MODE = 8'h16;
    localparam logic [7:0] ADDR_BUF0_LO = 8'he0;
    localparam logic [7:0] ADDR_BUF0_LO_END = 8'he7;
    localparam logic [7:0] ADDR_BUF0_HI = 8'hf8;
    localparam logic [7:0] ADDR_BUF_BASE = 8'he0;
    localparam logic [7:0] ADDR_BUF_END = 8'hff;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int BIT_ADDR_EN = 7;
    localparam int BIT_SETUP = 7;
    localparam int BIT_IN = 6;
    localparam int BIT_OUT = 5;
    localparam int BIT_ACK = 4;
    localparam int BIT_TOGGLE = 7;
    localparam int BIT_VALID = 6;
    localparam logic [7:0] MASK_EP12_MODE = 8'h1f;
    localparam logic [7:0] MASK_CNT = 8'hcf;
    localparam logic [3:0] MAX_COUNT = 4'h8;
    localparam int NUM_EP = 3;
    localparam int BUF_DEPTH = 8;
    localparam int CLK_MHZ = 20;
    localparam int BUS_RESET_US = 8;
    // Longer than the time, so round the count up and add one.
    localparam int BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ + 1;
    localparam int RST_CNT_W = 9;
    typedef enum logic [1:0] {
        TOK_NONE = 2'b00,
        TOK_SETUP = 2'b01,
        TOK_IN = 2'b10,
        TOK_OUT = 2'b11
    } usbdev_tok_t;
endpackage

// ==== design/usbdev_sync.sv ====
// Two flip-flop synchroniser for the data line levels.
`timescale 1ns/1ns
module usbdev_sync (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] din,
    output logic [1:0] dout
);
    logic [1:0] meta_ff;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 2'h3;
            dout <= 2'h3;
        end else begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule // usbdev_sync

// ==== design/usbdev_busrst.sv ====
// Detector for a single-ended zero held long enough to be a bus reset.
`timescale 1ns/1ns
module usbdev_busrst
    import usbdev_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] lines,
    output logic bus_reset
);
    logic [RST_CNT_W-1:0] cnt_ff;
    logic [RST_CNT_W-1:0] nxt_cnt;
    wire se0 = (lines == 2'h0);
    wire at_limit = (cnt_ff == RST_CNT_W'(BUS_RESET_CYC));
    wire at_prev = (cnt_ff == RST_CNT_W'(BUS_RESET_CYC - 1));
    assign nxt_cnt = !se0 ? '0 : (at_limit ? cnt_ff : cnt_ff + 1'b1);
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= '0;
            bus_reset <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            bus_reset <= se0 && at_prev;
        end
    end
endmodule // usbdev_busrst

// ==== design/usbdev_regs.sv ====
// Device address, endpoint mode and count registers with endpoint buffers.
`timescale 1ns/1ns
// Contract
// - Hardware reset clears address and enable.
// - Engine ignores traffic until address enabled; set-up data start and data bytes still act on endpoint zero.
// - Bus reset also clears address register.
// - Three endpoints, eight byte buffer each.
// - Endpoint zero bidirectional incl. set-up.
// - Reset clears all endpoint mode registers.
// - Endpoint zero token flags sticky, firmware clears.
// - Endpoints one, two lack token flags.
// - Acknowledge flag set on ACKed transaction.
// - Set-up flag held until first read after ACK start.
// - Engine update locks endpoint zero mode writes until read.
// - Engine updates at transaction end; set-up flag at set-up data start.
// - Set-up flag blocks endpoint zero buffer writes.
// - Mode low nibble selects endpoint response.
// - Count low nibble: IN bytes, 0-8.
// - Data valid only for OUT and set-up.
// - Count top bit selects DATA0 or DATA1.
// - Bus reset is SE0 over 8 us.
module usbdev_regs
    import usbdev_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_write_op,
    input wire logic io_read_op,
    output logic [7:0] io_rdata,
    input wire logic [1:0] usb_lines,
    input wire logic [6:0] tok_addr,
    input wire logic [1:0] tok_ep,
    input wire usbdev_pkg::usbdev_tok_t tok_pid,
    input wire logic tok_valid,
    input wire logic setup_data_start,
    input wire logic ack_start,
    input wire logic xfer_done,
    input wire logic xfer_acked,
    input wire logic [3:0] rx_count,
    input wire logic rx_valid,
    input wire logic rx_toggle,
    input wire logic rx_byte_we,
    input wire logic [2:0] rx_byte_idx,
    input wire logic [7:0] rx_byte,
    input wire logic [2:0] tx_byte_idx,
    output logic [7:0] tx_byte,
    output logic tok_match,
    output logic [3:0] ep_mode_out,
    output logic [3:0] ep_tx_count,
    output logic ep_tx_toggle,
    output logic bus_reset_seen
);
    import usbdev_pkg::*;

    // ------------------------------------------------------------
    // Line synchronisation and bus reset
    // ------------------------------------------------------------
    // The pins are asynchronous to core_clk, so nothing reads them before
    // the two-stage synchroniser.
    logic [1:0] lines_sync;
    logic bus_reset;
    usbdev_sync u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .din(usb_lines),
        .dout(lines_sync)
    );
    usbdev_busrst u_busrst (
        .core_clk(core_clk),
        .resetn(resetn),
        .lines(lines_sync),
        .bus_reset(bus_reset)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] dev_addr_ff;
    logic [7:0] mode_ff [NUM_EP];
    logic [7:0] cnt_ff [NUM_EP];
    logic [7:0] buf_mem [NUM_EP][BUF_DEPTH];
    logic lock_ff;
    logic setup_hold_ff;
    logic [1:0] cur_ep_ff;
    usbdev_tok_t cur_tok_ff;

    function automatic logic [1:0] buf_ep(input logic [7:0] a);
        buf_ep = 2'(3'(a[4:3]) == 3'h3 ? 2'h0 : a[4:3]);
    endfunction

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire wr_dev = io_write_op && io_addr == ADDR_DEV;
    wire wr_m0 = io_write_op && io_addr == ADDR_EP0_MODE;
    wire rd_m0 = io_read_op && io_addr == ADDR_EP0_MODE;
    wire is_buf = io_addr >= ADDR_BUF_BASE;
    // Both endpoint zero windows are guarded so a set-up cannot collide
    // with an IN buffer that firmware is still filling.
    wire buf0_win = (io_addr >= ADDR_BUF0_LO && io_addr <= ADDR_BUF0_LO_END)
                    || io_addr >= ADDR_BUF0_HI;
    wire setup_flag = mode_ff[0][BIT_SETUP];
    wire buf_wr_ok = io_write_op && is_buf
                     && !(setup_flag && buf0_win);
    wire [1:0] buf_sel = buf_ep(io_addr);
    wire addr_en = dev_addr_ff[BIT_ADDR_EN];
    wire match = tok_valid && addr_en && tok_addr == dev_addr_ff[6:0]
                 && tok_ep < 2'(NUM_EP);
    wire upd = xfer_done;
    wire upd0 = upd && cur_ep_ff == 2'h0;
    wire rx_tok = cur_tok_ff == TOK_OUT || cur_tok_ff == TOK_SETUP;

    // ------------------------------------------------------------
    // Address register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dev_addr_ff <= REG_RESET;
        end else if (bus_reset) begin
            dev_addr_ff <= REG_RESET;
        end else if (wr_dev) begin
            dev_addr_ff <= io_wdata;
        end
    end

    // ------------------------------------------------------------
    // Current transaction tracking
    // ------------------------------------------------------------
    // A token for another device or endpoint leaves these untouched, so
    // the engine outputs keep describing the last accepted transaction.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cur_ep_ff <= 2'h0;
            cur_tok_ff <= TOK_NONE;
        end else if (match) begin
            cur_ep_ff <= tok_ep;
            cur_tok_ff <= tok_pid;
        end else if (upd) begin
            cur_tok_ff <= TOK_NONE;
        end
    end

    // ------------------------------------------------------------
    // Set-up data phase
    // ------------------------------------------------------------
    // A read that lands between the start of the set-up data and the
    // start of the ACK must not release the set-up flag, so the phase
    // itself is remembered here.
    logic su_phase_ff;
    wire su_start = setup_data_start && cur_ep_ff == 2'h0;
    wire hold_rel = rd_m0 && !su_phase_ff && !ack_start;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            su_phase_ff <= 1'b0;
        end else if (su_start) begin
            su_phase_ff <= 1'b1;
        end else if (ack_start) begin
            su_phase_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Endpoint zero lock and set-up hold
    // ------------------------------------------------------------
    // A read in the same cycle as an engine update leaves the lock set,
    // so the newer engine value is never overwritten unseen.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lock_ff <= 1'b0;
            setup_hold_ff <= 1'b0;
        end else begin
            if (upd0 && cur_tok_ff != TOK_NONE) begin
                lock_ff <= 1'b1;
            end else if (rd_m0) begin
                lock_ff <= 1'b0;
            end
            if (su_start) begin
                setup_hold_ff <= 1'b1;
            end else if (hold_rel) begin
                setup_hold_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode and count registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            wire sel = upd && cur_ep_ff == 2'(g) && cur_tok_ff != TOK_NONE;
            wire [7:0] a_mode = g == 0 ? ADDR_EP0_MODE
                                : (g == 1 ? ADDR_EP1_MODE : ADDR_EP2_MODE);
            wire [7:0] a_cnt = g == 0 ? ADDR_EP0_CNT
                               : (g == 1 ? ADDR_EP1_CNT : ADDR_EP2_CNT);
            wire wr_m = io_write_op && io_addr == a_mode;
            wire wr_c = io_write_op && io_addr == a_cnt;
            logic [7:0] nxt_mode;
            logic [7:0] nxt_cnt;
            logic [7:0] tok_bits;
            always_comb begin
                tok_bits = 8'h00;
                if (g == 0) begin
                    tok_bits[BIT_SETUP] = cur_tok_ff == TOK_SETUP;
                    tok_bits[BIT_IN] = cur_tok_ff == TOK_IN;
                    tok_bits[BIT_OUT] = cur_tok_ff == TOK_OUT;
                end
                nxt_mode = mode_ff[g];
                if (wr_m && !(g == 0 && lock_ff)) begin
                    nxt_mode = io_wdata;
                    if (g == 0 && setup_hold_ff) begin
                        nxt_mode[BIT_SETUP] = 1'b1;
                    end
                end
                if (g == 0 && setup_data_start && cur_ep_ff == 2'h0) begin
                    nxt_mode[BIT_SETUP] = 1'b1;
                end
                if (sel) begin
                    // Engine set wins over a firmware clear in the same cycle.
                    nxt_mode = nxt_mode | tok_bits;
                    if (xfer_acked) begin
                        nxt_mode[BIT_ACK] = 1'b1;
                    end
                end
                if (g != 0) begin
                    nxt_mode = nxt_mode & MASK_EP12_MODE;
                end
                nxt_cnt = wr_c ? (io_wdata & MASK_CNT) : cnt_ff[g];
                if (sel && rx_tok) begin
                    nxt_cnt[3:0] = rx_count;
                    nxt_cnt[BIT_VALID] = rx_valid;
                    nxt_cnt[BIT_TOGGLE] = rx_toggle;
                end
            end
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    mode_ff[g] <= REG_RESET;
                    cnt_ff[g] <= REG_RESET;
                end else begin
                    mode_ff[g] <= nxt_mode;
                    cnt_ff[g] <= nxt_cnt;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Endpoint buffers
    // ------------------------------------------------------------
    // The buffers have no reset: firmware fills a buffer before it arms
    // an IN response, and a reset network on 24 bytes buys nothing.
    // endpoint zero also receives; every buffer is two-way.
    always_ff @(posedge core_clk) begin
        if (rx_byte_we && (rx_tok || cur_ep_ff == 2'h0)) begin
            buf_mem[cur_ep_ff][rx_byte_idx] <= rx_byte;
        end else if (buf_wr_ok) begin
            buf_mem[buf_sel][io_addr[2:0]] <= io_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read mux and engine outputs
    // ------------------------------------------------------------
    logic [7:0] nxt_rdata;
    always_comb begin
        case (io_addr)
            ADDR_DEV: nxt_rdata = dev_addr_ff;
            ADDR_EP0_CNT: nxt_rdata = cnt_ff[0];
            ADDR_EP0_MODE: nxt_rdata = mode_ff[0];
            ADDR_EP1_CNT: nxt_rdata = cnt_ff[1];
            ADDR_EP1_MODE: nxt_rdata = mode_ff[1];
            ADDR_EP2_CNT: nxt_rdata = cnt_ff[2];
            ADDR_EP2_MODE: nxt_rdata = mode_ff[2];
            default: nxt_rdata = is_buf ? buf_mem[buf_sel][io_addr[2:0]]
                                        : 8'h00;
        endcase
    end
    wire [3:0] cnt_lo = cnt_ff[cur_ep_ff][3:0];
    // Counts above eight are clipped so the engine never overruns a buffer.
    wire [3:0] clip_cnt = cnt_lo > MAX_COUNT ? MAX_COUNT : cnt_lo;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            io_rdata <= 8'h00;
            tx_byte <= 8'h00;
            tok_match <= 1'b0;
            ep_mode_out <= 4'h0;
            ep_tx_count <= 4'h0;
            ep_tx_toggle <= 1'b0;
            bus_reset_seen <= 1'b0;
        end else begin
            io_rdata <= io_read_op ? nxt_rdata : io_rdata;
            tx_byte <= buf_mem[cur_ep_ff][tx_byte_idx];
            tok_match <= match;
            ep_mode_out <= mode_ff[cur_ep_ff][3:0];
            ep_tx_count <= clip_cnt;
            ep_tx_toggle <= cnt_ff[cur_ep_ff][BIT_TOGGLE];
            bus_reset_seen <= bus_reset;
        end
    end
endmodule // usbdev_regs

// ==== tb/usbdev_regs_asserts.sv ====
// Checker for the endpoint register block ports.
`timescale 1ns/1ns
module usbdev_regs_asserts
    import usbdev_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] io_addr,
    input wire logic io_write_op,
    input wire logic io_read_op,
    input wire logic [7:0] io_rdata,
    input wire logic [1:0] usb_lines,
    input wire logic [1:0] tok_ep,
    input wire logic tok_valid,
    input wire logic tok_match,
    input wire logic [3:0] ep_tx_count,
    input wire logic bus_reset_seen
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ----------
    // Pin-level single-ended zero run length.
    // ----------
    // It saturates so that a long reset never wraps back below the bound.
    logic [8:0] se0_cnt_ff;
    logic [8:0] nxt_se0_cnt;
    wire rd_dev = io_read_op && io_addr == ADDR_DEV && !io_write_op;
    assign nxt_se0_cnt = (usb_lines != 2'b00) ? 9'h000 :
        (se0_cnt_ff == 9'h1ff) ? se0_cnt_ff : se0_cnt_ff + 9'h001;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            se0_cnt_ff <= 9'h000;
        end else begin
            se0_cnt_ff <= nxt_se0_cnt;
        end
    end
    property p_tok_cause; !tok_valid |=> !tok_match; endproperty
    a_tok_cause: assert property (p_tok_cause)
        else $error("stray match");
    property p_tok_ep; tok_valid && tok_ep == 2'd3 |=> !tok_match; endproperty
    a_tok_ep: assert property (p_tok_ep) else $error("ep3 matched");
    property p_se0_len; bus_reset_seen |-> se0_cnt_ff >= 9'd160; endproperty
    a_se0_len: assert property (p_se0_len)
        else $error("early reset");
    property p_rst_pulse; bus_reset_seen |=> !bus_reset_seen; endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("long pulse");
    property p_cnt_clip; ep_tx_count <= MAX_COUNT; endproperty
    a_cnt_clip: assert property (p_cnt_clip)
        else $error("count above 8");
    property p_rd_hold; !io_read_op |=> $stable(io_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("rdata moved");
    property p_ep12_resv; io_read_op && (io_addr == ADDR_EP1_MODE ||
        io_addr == ADDR_EP2_MODE) |=> io_rdata[7:5] == 3'b000; endproperty
    a_ep12_resv: assert property (p_ep12_resv)
        else $error("flags set");
    property p_busrst_addr; bus_reset_seen ##0 (!io_write_op throughout
        (##[2:400] rd_dev)) |=> io_rdata == 8'h00; endproperty
    a_busrst_addr: assert property (p_busrst_addr)
        else $error("addr kept");
    c_tok: cover property (tok_match);
    c_rst: cover property (bus_reset_seen);
    c_setup: cover property (io_read_op && io_addr == ADDR_EP0_MODE ##1
        io_rdata[7]);
endmodule // usbdev_regs_asserts
bind usbdev_regs usbdev_regs_asserts usbdev_regs_asserts_i (.core_clk,
    .resetn, .io_addr, .io_write_op, .io_read_op, .io_rdata, .usb_lines,
    .tok_ep, .tok_valid, .tok_match, .ep_tx_count, .bus_reset_seen);

// ==== tb/usbdev_host_model.sv ====
// Host and line model that drives the serial engine events.
`timescale 1ns/1ns
module usbdev_host_model
    import usbdev_pkg::*;
(
    input wire logic core_clk,
    output logic [1:0] usb_lines,
    output logic [6:0] tok_addr,
    output logic [1:0] tok_ep,
    output usbdev_pkg::usbdev_tok_t tok_pid,
    output logic tok_valid,
    output logic setup_data_start,
    output logic ack_start,
    output logic xfer_done,
    output logic xfer_acked,
    output logic [3:0] rx_count,
    output logic rx_valid,
    output logic rx_toggle,
    output logic rx_byte_we,
    output logic [2:0] rx_byte_idx,
    output logic [7:0] rx_byte
);
    // ----------
    // Transaction tasks.
    // ----------
    // Idle is the low-speed J state, D- high.
    initial begin
        {usb_lines, tok_addr, tok_ep, tok_valid} = {2'b01, 10'h000};
        tok_pid = TOK_NONE;
        {setup_data_start, ack_start, xfer_done, xfer_acked} = 4'h0;
        {rx_count, rx_valid, rx_toggle, rx_byte_we} = 7'h00;
        {rx_byte_idx, rx_byte} = 11'h000;
    end
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic tok(input logic [6:0] a, input logic [1:0] e,
        input usbdev_tok_t p);
        step();
        {tok_addr, tok_ep, tok_valid} = {a, e, 1'b1};
        tok_pid = p;
        step();
        {tok_addr, tok_valid} = {~a, 1'b0};
    endtask
    // A non-zero gap models a slow host between data bytes.
    task automatic xact(input logic su, input logic [3:0] cnt,
        input logic tog, input int gap);
        if (su) begin
            step();
            setup_data_start = 1'b1;
            step();
            setup_data_start = 1'b0;
        end
        for (int i = 0; i < cnt; i++) begin
            step();
            {rx_byte_we, rx_byte_idx, rx_byte} = {1'b1, 3'(i), 8'h30 + 8'(i)};
            step();
            {rx_byte_we, rx_byte} = {1'b0, ~rx_byte};
            repeat (gap) step();
        end
        step();
        ack_start = 1'b1;
        step();
        ack_start = 1'b0;
        {xfer_done, xfer_acked, rx_valid} = 3'b111;
        {rx_count, rx_toggle} = {cnt, tog};
        step();
        {xfer_done, xfer_acked} = 2'b00;
    endtask
    task automatic se0(input int len);
        step();
        usb_lines = 2'b00;
        repeat (len) step();
        usb_lines = 2'b01;
        repeat (4) step();
    endtask
endmodule // usbdev_host_model

// ==== tb/tb_usb_device_endpoint_regs.sv ====
// Self-checking bench for the endpoint register block.
`timescale 1ns/1ns
module tb_usb_device_endpoint_regs;
    import usbdev_pkg::*;
    logic core_clk, resetn, io_write_op, io_read_op, tok_valid, tok_match;
    logic [7:0] io_addr, io_wdata, io_rdata, tx_byte, rx_byte, d;
    logic [7:0] bf [8];
    logic [2:0] tx_byte_idx, rx_byte_idx;
    logic [1:0] usb_lines, tok_ep;
    logic [6:0] tok_addr;
    logic [3:0] rx_count, ep_mode_out, ep_tx_count, n;
    usbdev_tok_t tok_pid;
    logic setup_data_start, ack_start, xfer_done, xfer_acked, rx_valid;
    logic rx_toggle, rx_byte_we, ep_tx_toggle, bus_reset_seen, tg;
    logic rst_seen = 1'b0;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    integer seed = 32'h07a4;
    usbdev_regs usbdev_regs_i (.core_clk, .resetn, .io_addr, .io_wdata,
        .io_write_op, .io_read_op, .io_rdata, .usb_lines, .tok_addr, .tok_ep,
        .tok_pid, .tok_valid, .setup_data_start, .ack_start, .xfer_done,
        .xfer_acked, .rx_count, .rx_valid, .rx_toggle, .rx_byte_we,
        .rx_byte_idx, .rx_byte, .tx_byte_idx, .tx_byte, .tok_match,
        .ep_mode_out, .ep_tx_count, .ep_tx_toggle, .bus_reset_seen);
    usbdev_host_model usbdev_host_model_i (.core_clk, .usb_lines, .tok_addr,
        .tok_ep, .tok_pid, .tok_valid, .setup_data_start, .ack_start,
        .xfer_done, .xfer_acked, .rx_count, .rx_valid, .rx_toggle,
        .rx_byte_we, .rx_byte_idx, .rx_byte);
    // ----------
    // Clock, watchdog and access tasks.
    // ----------
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        rst_seen <= rst_seen | (bus_reset_seen === 1'b1);
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    // Expected IN byte count: anything beyond a full buffer is sent as full.
    function automatic logic [3:0] exp_tx(input logic [3:0] c);
        exp_tx = (c > MAX_COUNT) ? MAX_COUNT : c;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        step();
        {io_addr, io_wdata, io_write_op} = {a, v, 1'b1};
        step();
        io_write_op = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        step();
        {io_addr, io_read_op} = {a, 1'b1};
        step();
        io_read_op = 1'b0;
        v = io_rdata;
    endtask
    task automatic tk(input logic [6:0] a, input logic [1:0] e,
        input usbdev_tok_t p, input logic exp);
        usbdev_host_model_i.tok(a, e, p);
        chk({7'h00, tok_match}, {7'h00, exp});
    endtask
    initial begin
        {resetn, io_addr, io_wdata, io_write_op, io_read_op} = 19'h00000;
        tx_byte_idx = 3'h0;
        repeat (5) @(posedge core_clk);
        #1 resetn = 1'b1;
        for (int a = 16; a < 24; a++) begin
            rd(8'(a), d);
            chk(d, 8'h00);
        end
        tk(7'h00, 2'd0, TOK_SETUP, 1'b0);
        wr(ADDR_DEV, 8'h85);
        tk(7'h05, 2'd3, TOK_IN, 1'b0);
        tk(7'h06, 2'd0, TOK_IN, 1'b0);
        tk(7'h05, 2'd0, TOK_SETUP, 1'b1);
        n = 4'(1 + $unsigned($random(seed)) % 8);
        tg = $random(seed);
        usbdev_host_model_i.xact(1'b1, n, tg, 0);
        wr(ADDR_EP0_MODE, 8'h03);
        wr(8'he0, 8'h5a);
        step();
        chk(tx_byte, 8'h30);
        rd(ADDR_EP0_MODE, d);
        chk(d & 8'h9f, 8'h90);
        rd(ADDR_EP0_CNT, d);
        chk(d, {tg, 3'b100, n});
        wr(ADDR_EP0_MODE, 8'h02);
        rd(ADDR_EP0_MODE, d);
        chk(d, 8'h02);
        chk({4'h0, ep_mode_out}, 8'h02);
        wr(8'he0, 8'h5a);
        step();
        chk(tx_byte, 8'h5a);
        tk(7'h05, 2'd1, TOK_OUT, 1'b1);
        usbdev_host_model_i.xact(1'b0, 4'h4, 1'b1, 2);
        rd(ADDR_EP1_MODE, d);
        chk(d, 8'h10);
        wr(ADDR_EP1_MODE, 8'hff);
        rd(ADDR_EP1_MODE, d);
        chk(d, 8'h1f);
        chk({4'h0, ep_mode_out}, 8'h0f);
        for (int k = 0; k < 6; k++) begin
            // The third pass asks for more than a buffer holds.
            n = (k == 2) ? 4'hf : 4'($unsigned($random(seed)) % 9);
            n = (k < 2) ? 4'(8 - 8 * k) : n;
            tg = $random(seed);
            wr(ADDR_EP1_CNT, {tg, 3'b000, n});
            tk(7'h05, 2'd1, TOK_IN, 1'b1);
            d = {3'h0, tg, exp_tx(n)};
            chk({3'h0, ep_tx_toggle, ep_tx_count}, d);
        end
        tk(7'h05, 2'd2, TOK_IN, 1'b1);
        for (int i = 0; i < 8; i++) begin
            bf[i] = $random(seed);
            wr(8'hf0 + 8'(i), bf[i]);
        end
        for (int i = 0; i < 8; i++) begin
            tx_byte_idx = 3'(i);
            step();
            chk(tx_byte, bf[i]);
        end
        // Reads and writes inside the set-up data phase must not free bit 7.
        tk(7'h05, 2'd0, TOK_SETUP, 1'b1);
        fork
            usbdev_host_model_i.xact(1'b1, 4'h2, 1'b0, 3);
            begin
                repeat (3) step();
                rd(ADDR_EP0_MODE, d);
                wr(ADDR_EP0_MODE, 8'h00);
                rd(ADDR_EP0_MODE, d);
                chk(d, 8'h80);
            end
        join
        rd(ADDR_EP0_MODE, d);
        chk(d, 8'h90);
        usbdev_host_model_i.se0(100);
        rd(ADDR_DEV, d);
        chk({d[7:1], rst_seen}, 8'h84);
        usbdev_host_model_i.se0(200);
        rd(ADDR_DEV, d);
        chk({d[7:1], rst_seen}, 8'h01);
        tk(7'h05, 2'd0, TOK_IN, 1'b0);
        results();
    end
endmodule // tb_usb_device_endpoint_regs
